/* File: smrs_link_sampler.sv */
// samples the data line on each rising edge of the bus clock
module smrs_link_sampler (
  input wire logic scl_i,
  input wire logic nrst_i,
  input wire logic sda_i,
  output logic bit_o,
  output logic tgl_o
);
  // link side state
  typedef struct packed {
    logic bit_v;
    logic tgl;
  } smrs_link_t;

  smrs_link_t q, d;

  // capture the bit and flag a new one with a toggle
  always_comb begin
    d = q;
    d.bit_v = sda_i;
    d.tgl = ~q.tgl;
  end

  // register on the bus clock
  always_ff @(posedge scl_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bit_o = q.bit_v;
  assign tgl_o = q.tgl;
endmodule

/* File: smrs_master.sv */
// bus master model: drives the bus clock and pulls the data wire
module smrs_master #(
  parameter int HALF = 128
) (
  input wire logic sda_i,
  output logic scl_o,
  output logic pull_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int Q = HALF / 2;
  // last byte read, toggled flag for the bench watcher
  logic [7:0] rd_val;
  logic rd_tgl;
  // idle: clock high and standing still, data released
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
    rd_val = 8'h00;
    rd_tgl = 1'b0;
  end
  // start or repeated start: data falls while clock high
  task automatic start();
    #Q pull_o = 1'b0;
    #Q scl_o = 1'b1;
    #HALF pull_o = 1'b1;
    #HALF scl_o = 1'b0;
  endtask
  // data changes only mid low phase
  task automatic put_bit(input logic b);
    #Q pull_o = !b;
    #Q scl_o = 1'b1;
    #HALF scl_o = 1'b0;
  endtask
  // released wire, sampled just before the clock falls
  task automatic get_bit(output logic b);
    #Q pull_o = 1'b0;
    #Q scl_o = 1'b1;
    #HALF b = sda_i;
    scl_o = 1'b0;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i]);
    end
    get_bit(b);
    ack = !b;
  endtask
  // nack high ends a read
  task automatic rd_byte(input logic nack, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      get_bit(v[i]);
    end
    put_bit(nack);
    rd_val = v;
    rd_tgl = !rd_tgl;
  endtask
  // stop: data low, clock high, data rises
  task automatic stop();
    #Q pull_o = 1'b1;
    #Q scl_o = 1'b1;
    #HALF pull_o = 1'b0;
    #HALF;
  endtask
endmodule

/* File: smrs_pkg.sv */
package smrs_pkg;
  // fixed upper five bits of the bus address
  localparam logic [4:0] ADDR_FIXED = 5'h13;
  // user ram window and its size
  localparam logic [7:0] RAM_LAST = 8'hDF;
  localparam int RAM_WORDS = 224;
  // configuration update register and its erase enable bit
  localparam logic [7:0] REG_CFG_UPD = 8'h90;
  localparam int CFG_ERASE_EN_BIT = 2;
  // identification registers
  localparam logic [7:0] REG_MAKER_ID = 8'hF4;
  localparam logic [7:0] REG_REVISION = 8'hF5;
  localparam logic [7:0] REG_BRAND_ONE = 8'hF6;
  localparam logic [7:0] REG_BRAND_TWO = 8'hF7;
  // nonvolatile and ram high address bytes
  localparam logic [7:0] NV_HI_FIRST = 8'hF8;
  localparam logic [7:0] NV_HI_LAST = 8'hFB;
  localparam logic [7:0] ENG_HI_FIRST = 8'hFA;
  localparam logic [7:0] RAM_HI = 8'h00;
  // instruction command codes
  localparam logic [7:0] CMD_BLK_WR = 8'hFC;
  localparam logic [7:0] CMD_BLK_RD = 8'hFD;
  localparam logic [7:0] CMD_ERASE = 8'hFE;
  // block read byte count, erased byte value
  localparam logic [7:0] BLK_RD_COUNT = 8'h20;
  localparam logic [7:0] NV_BLANK = 8'hFF;
  // page select bits of the pointer
  localparam int PAGE_LSB = 5;
  localparam int PAGE_W = 16 - PAGE_LSB;
  // bit counter positions
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int DL_TIME_US = 1000;
  localparam int DL_CYCLES = DL_TIME_US * CLK_MHZ;
  localparam int ERASE_TIME_MS = 20;
  localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 22;
  // protocol states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_RX,
    ST_TX,
    ST_SKIP
  } smrs_state_t;
endpackage

/* File: smrs_slave.sv */
// Notes on behaviour
// - address is 10011 plus two select pins
// - refuse access until download finishes
// - four read-only identification registers F4-F7
// - start is data falling while clock high
// - first byte: address then direction bit
// - matched address acked low through ninth pulse
// - nine clocks per byte, data changes low
// - first written byte is the command
// - ram 00-DF, nonvolatile F800-FBFF
// - program blank bytes only, erase pages
// - erase only when enable bit set
// - send byte ram address loads pointer
// - command FE erases the pointer page
// - erase starts at once, nack while busy
// - write byte to ram stores data
// - write byte F8-FB sets nonvolatile pointer
// - erase uses only page bits of pointer
// - write word F8-FB programs one byte
// - FC starts block write at pointer
// - FD requests block read at pointer
// - engine running refuses its nonvolatile range
module smrs_slave #(
  parameter int DL_CYC = smrs_pkg::DL_CYCLES,
  parameter int ERASE_CYC = smrs_pkg::ERASE_CYCLES,
  // identification values, arbitrary
  parameter logic [7:0] MAKER_ID_VAL = 8'hA5,
  parameter logic [7:0] REVISION_VAL = 8'h1C,
  parameter logic [7:0] BRAND_ONE_VAL = 8'h3E,
  parameter logic [7:0] BRAND_TWO_VAL = 8'h7B
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_select_high_pin_i,
  input wire logic addr_select_low_pin_i,
  input wire logic sequencing_engine_run_i,
  output logic [15:0] nv_addr_o,
  input wire logic [7:0] nv_rdata_i,
  output logic [7:0] nv_wdata_o,
  output logic nv_wr_o,
  output logic nv_erase_o,
  output logic [10:0] nv_erase_page_o,
  output logic erase_busy_o,
  output logic download_done_o,
  output logic ram_wr_o,
  output logic [7:0] ram_addr_o,
  output logic [7:0] ram_wdata_o,
  output logic [7:0] config_update_control_o
);
  // all core-clock state of the slave
  typedef struct packed {
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic tg_s1, tg_s2, tg_s3, tg_s4;
    logic bit_s1, bit_s2;
    logic ah_s1, ah_s2, al_s1, al_s2;
    smrs_pkg::smrs_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] sh;
    logic [1:0] nbyte;
    logic [7:0] cmd;
    logic [15:0] ptr;
    logic ack;
    logic [7:0] tx;
    logic blk_rd;
    logic oe;
    logic nv_wr;
    logic [7:0] nv_wdata;
    logic nv_erase;
    logic ram_wr;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic dl_done;
    logic [smrs_pkg::CNT_W-1:0] dl_cnt;
    logic er_busy;
    logic [smrs_pkg::CNT_W-1:0] er_cnt;
    logic [smrs_pkg::RAM_WORDS-1:0][7:0] ram;
  } smrs_regs_t;

  smrs_regs_t q, d;
  logic link_bit; // sampled bit, link domain
  logic link_tgl; // new-bit toggle, link domain
  logic start_c, stop_c, fall_c, bit_ev;
  logic [7:0] rd_byte; // byte at the pointer
  logic [7:0] cfg_reg;
  // every check below samples on the core clock
  default clocking chk_cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  // ram window test
  function automatic logic is_ram(input logic [7:0] b);
    return b <= smrs_pkg::RAM_LAST;
  endfunction

  // identification register test
  function automatic logic is_id(input logic [7:0] b);
    return b >= smrs_pkg::REG_MAKER_ID && b <= smrs_pkg::REG_BRAND_TWO;
  endfunction

  // nonvolatile high byte test
  function automatic logic is_nv(input logic [7:0] b);
    return b >= smrs_pkg::NV_HI_FIRST && b <= smrs_pkg::NV_HI_LAST;
  endfunction

  // engine range blocked while the engine runs
  function automatic logic eng_hit(input logic [7:0] hi, input logic run);
    return run && hi >= smrs_pkg::ENG_HI_FIRST && hi <= smrs_pkg::NV_HI_LAST;
  endfunction

  // link side bit capture on the bus clock
  smrs_link_sampler u_link (
    .scl_i(scl_i),
    .nrst_i(nrst_i),
    .sda_i(sda_i),
    .bit_o(link_bit),
    .tgl_o(link_tgl)
  );

  // bus conditions from synchronised pins
  assign start_c = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
  assign stop_c = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
  assign fall_c = q.scl_s3 & ~q.scl_s2;
  // one late stage so the bit is settled when the event is seen
  assign bit_ev = q.tg_s3 ^ q.tg_s4;
  assign cfg_reg = q.ram[smrs_pkg::REG_CFG_UPD];

  // read mux: ram, identification or nonvolatile
  always_comb begin
    rd_byte = 8'h00;
    if (is_nv(q.ptr[15:8])) begin
      rd_byte = nv_rdata_i;
    end else if (q.ptr[15:8] == smrs_pkg::RAM_HI) begin
      if (is_ram(q.ptr[7:0])) begin
        rd_byte = q.ram[q.ptr[7:0]];
      end else begin
        case (q.ptr[7:0])
          smrs_pkg::REG_MAKER_ID: rd_byte = MAKER_ID_VAL;
          smrs_pkg::REG_REVISION: rd_byte = REVISION_VAL;
          smrs_pkg::REG_BRAND_ONE: rd_byte = BRAND_ONE_VAL;
          smrs_pkg::REG_BRAND_TWO: rd_byte = BRAND_TWO_VAL;
          default: rd_byte = 8'h00;
        endcase
      end
    end
  end

  // next core-clock state of the whole slave
  always_comb begin
    logic [7:0] b;
    logic wr_go;
    b = {q.sh[6:0], q.bit_s2};
    wr_go = 1'b0;
    d = q;
    // strobes last one cycle
    d.nv_wr = 1'b0;
    d.nv_erase = 1'b0;
    d.ram_wr = 1'b0;
    // two-stage synchronisers, with extra history stages on scl, sda and the toggle for edge detection
    d.scl_s1 = scl_i;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = sda_i;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.tg_s1 = link_tgl;
    d.tg_s2 = q.tg_s1;
    d.tg_s3 = q.tg_s2;
    d.tg_s4 = q.tg_s3;
    d.bit_s1 = link_bit;
    d.bit_s2 = q.bit_s1;
    d.ah_s1 = addr_select_high_pin_i;
    d.ah_s2 = q.ah_s1;
    d.al_s1 = addr_select_low_pin_i;
    d.al_s2 = q.al_s1;
    // power-up download timer
    if (!q.dl_done) begin
      if (q.dl_cnt == smrs_pkg::CNT_W'(DL_CYC - 1)) begin
        d.dl_done = 1'b1;
      end else begin
        d.dl_cnt = q.dl_cnt + 1'b1;
      end
    end
    // erase timer
    if (q.er_busy) begin
      if (q.er_cnt == smrs_pkg::CNT_W'(ERASE_CYC - 1)) begin
        d.er_busy = 1'b0;
      end else begin
        d.er_cnt = q.er_cnt + 1'b1;
      end
    end
    // bus protocol
    if (start_c) begin
      d.state = smrs_pkg::ST_ADDR;
      d.bit_cnt = 4'h0;
      d.oe = 1'b0;
      d.ack = 1'b0;
    end else if (stop_c) begin
      d.state = smrs_pkg::ST_IDLE;
      d.oe = 1'b0;
      d.ack = 1'b0;
    end else begin
      // change the drive only just after the clock falls
      if (fall_c) begin
        if (q.bit_cnt == smrs_pkg::ACK_SLOT) begin
          d.oe = q.ack;
        end else if (q.state == smrs_pkg::ST_TX) begin
          d.oe = ~q.tx[7];
        end else begin
          d.oe = 1'b0;
        end
      end
      if (bit_ev && q.state != smrs_pkg::ST_IDLE &&
          q.state != smrs_pkg::ST_SKIP) begin
        if (q.bit_cnt == smrs_pkg::ACK_SLOT) begin
          // ninth clock: byte group ends
          d.bit_cnt = 4'h0;
          d.ack = 1'b0;
          if (q.state == smrs_pkg::ST_TX) begin
            // the address ack keeps the count or first byte already loaded
            d.nbyte = 2'h1;
            if (q.bit_s2) begin
              d.state = smrs_pkg::ST_SKIP;
            end else if (q.nbyte != 2'h0) begin
              d.tx = rd_byte;
              if (q.blk_rd) begin
                d.ptr = q.ptr + 16'h0001;
              end
            end
          end
        end else begin
          d.bit_cnt = q.bit_cnt + 4'h1;
          d.sh = b;
          if (q.state == smrs_pkg::ST_TX) begin
            d.tx = {q.tx[6:0], 1'b0};
          end
          if (q.bit_cnt == smrs_pkg::LAST_DATA_BIT) begin
            case (q.state)
              smrs_pkg::ST_ADDR: begin
                // address byte with direction bit
                if (b[7:1] == {smrs_pkg::ADDR_FIXED, q.ah_s2, q.al_s2} &&
                    q.dl_done && !q.er_busy &&
                    !(b[0] && eng_hit(q.ptr[15:8],
                      sequencing_engine_run_i))) begin
                  d.ack = 1'b1;
                  d.nbyte = 2'h0;
                  if (b[0]) begin
                    d.state = smrs_pkg::ST_TX;
                    d.tx = q.blk_rd ? smrs_pkg::BLK_RD_COUNT : rd_byte;
                  end else begin
                    d.state = smrs_pkg::ST_RX;
                  end
                end else begin
                  d.state = smrs_pkg::ST_SKIP;
                end
              end
              smrs_pkg::ST_RX: begin
                d.ack = 1'b1;
                d.nbyte = (q.nbyte == 2'h3) ? 2'h3 : q.nbyte + 2'h1;
                if (q.nbyte == 2'h0) begin
                  // command byte
                  d.cmd = b;
                  d.blk_rd = 1'b0;
                  if (eng_hit(b, sequencing_engine_run_i) ||
                      ((b == smrs_pkg::CMD_BLK_WR ||
                        b == smrs_pkg::CMD_BLK_RD ||
                        b == smrs_pkg::CMD_ERASE) &&
                       eng_hit(q.ptr[15:8], sequencing_engine_run_i))) begin
                    d.ack = 1'b0;
                    d.state = smrs_pkg::ST_SKIP;
                  end else if (is_ram(b) || is_id(b)) begin
                    d.ptr = {smrs_pkg::RAM_HI, b};
                  end else if (b == smrs_pkg::CMD_ERASE) begin
                    if (cfg_reg[smrs_pkg::CFG_ERASE_EN_BIT]) begin
                      d.nv_erase = 1'b1;
                      d.er_busy = 1'b1;
                      d.er_cnt = '0;
                    end
                  end else if (b == smrs_pkg::CMD_BLK_RD) begin
                    d.blk_rd = 1'b1;
                  end
                  // other codes change nothing
                end else if (q.nbyte == 2'h1) begin
                  if (is_nv(q.cmd)) begin
                    d.ptr = {q.cmd, b};
                  end else if (is_ram(q.cmd)) begin
                    wr_go = 1'b1;
                  end
                  // block write count byte is not stored
                end else begin
                  if (is_nv(q.cmd) && q.nbyte == 2'h2) begin
                    wr_go = 1'b1;
                  end else if (q.cmd == smrs_pkg::CMD_BLK_WR) begin
                    wr_go = 1'b1;
                    d.ptr = q.ptr + 16'h0001;
                  end
                end
              end
              default: d.state = q.state;
            endcase
          end
        end
      end
    end
    // data write at the pointer
    if (wr_go) begin
      if (is_nv(q.ptr[15:8])) begin
        if (nv_rdata_i == smrs_pkg::NV_BLANK) begin
          d.nv_wr = 1'b1;
          d.nv_wdata = b;
        end
      end else if (q.ptr[15:8] == smrs_pkg::RAM_HI && is_ram(q.ptr[7:0]))
      begin
        d.ram[q.ptr[7:0]] = b;
        d.ram_wr = 1'b1;
        d.ram_addr = q.ptr[7:0];
        d.ram_wdata = b;
      end
    end
  end

  // one register for all core-clock state
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // open-drain data pin, only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe_o = q.oe;
  assign nv_addr_o = q.ptr;
  assign nv_wdata_o = q.nv_wdata;
  assign nv_wr_o = q.nv_wr;
  assign nv_erase_o = q.nv_erase;
  assign nv_erase_page_o = q.ptr[15:smrs_pkg::PAGE_LSB];
  assign erase_busy_o = q.er_busy;
  assign download_done_o = q.dl_done;
  assign ram_wr_o = q.ram_wr;
  assign ram_addr_o = q.ram_addr;
  assign ram_wdata_o = q.ram_wdata;
  assign config_update_control_o = cfg_reg;

  // checks
  a_addr_refused: assert property (
    (bit_ev && q.state == smrs_pkg::ST_ADDR &&
     q.bit_cnt == smrs_pkg::LAST_DATA_BIT && (q.er_busy || !q.dl_done))
    |=> q.state == smrs_pkg::ST_SKIP && !q.ack)
    else $error("address acked while busy or loading");
  a_download_first: assert property (
    q.state == smrs_pkg::ST_RX |-> download_done_o)
    else $error("write accepted before download done");
  a_ack_low: assert property (
    (fall_c && !start_c && !stop_c && q.ack &&
     q.bit_cnt == smrs_pkg::ACK_SLOT) |=> sda_oe_o [*2])
    else $error("acknowledge not driven low");
  a_addr_match: assert property (
    q.state == smrs_pkg::ST_ADDR ##1 q.state == smrs_pkg::ST_RX
    |-> q.sh[7:1] == {smrs_pkg::ADDR_FIXED, q.ah_s2, q.al_s2})
    else $error("write entered on wrong address");
  a_erase_enable: assert property (
    nv_erase_o |-> config_update_control_o[smrs_pkg::CFG_ERASE_EN_BIT]
    && erase_busy_o)
    else $error("erase without enable bit");
  a_erase_hold: assert property (
    $rose(erase_busy_o) |-> erase_busy_o [*8])
    else $error("erase busy ended too soon");
  a_nv_blank: assert property (
    nv_wr_o |-> $past(nv_rdata_i) == smrs_pkg::NV_BLANK)
    else $error("programmed a byte that was not blank");
  a_engine_guard: assert property (
    (bit_ev && !start_c && !stop_c && q.state == smrs_pkg::ST_RX &&
     q.nbyte == 2'h0 && q.bit_cnt == smrs_pkg::LAST_DATA_BIT &&
     sequencing_engine_run_i &&
     {q.sh[6:0], q.bit_s2} >= smrs_pkg::ENG_HI_FIRST &&
     {q.sh[6:0], q.bit_s2} <= smrs_pkg::NV_HI_LAST)
    |=> q.state == smrs_pkg::ST_SKIP && !q.ack)
    else $error("engine range command acked while running");
  a_ram_range: assert property (
    ram_wr_o |-> ram_addr_o <= smrs_pkg::RAM_LAST)
    else $error("ram write outside window");
  c_erase: cover property (nv_erase_o);
  c_nv_write: cover property (nv_wr_o);
  c_read: cover property (
    q.state == smrs_pkg::ST_TX ##1 q.state == smrs_pkg::ST_SKIP);
endmodule

/* File: testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DLC = 2000;
  localparam int ERC = 1000;
  // identification values, arbitrary
  localparam logic [7:0] IDV [4] = '{8'h5C, 8'h0E, 8'hD3, 8'h96};
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic a_hi = 1'b0;
  logic a_lo = 1'b0;
  logic eng_run = 1'b0;
  logic [7:0] nv_rdata = 8'hFF;
  logic sda_oe, sda_o, scl, pull, nv_wr, nv_erase, busy, dl_done, ram_wr;
  logic [15:0] nv_addr;
  logic [7:0] nv_wdata, ram_addr, ram_wdata, cfg;
  logic [10:0] page;
  // pulled-up open drain wire
  wire sda = !(pull || (sda_oe && !sda_o));
  int n_mismatch = 0;
  int checks_done = 0;
  int busy_cnt = 0;
  logic rd_seen = 1'b0;
  logic [27:0] expq[$]; // kind nibble, then value
  smrs_master #(.HALF(128)) m (.sda_i(sda), .scl_o(scl), .pull_o(pull));
  smrs_slave #(.DL_CYC(DLC), .ERASE_CYC(ERC), .MAKER_ID_VAL(IDV[0]),
    .REVISION_VAL(IDV[1]), .BRAND_ONE_VAL(IDV[2]),
    .BRAND_TWO_VAL(IDV[3])) dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_select_high_pin_i(a_hi),
    .addr_select_low_pin_i(a_lo), .sequencing_engine_run_i(eng_run),
    .nv_addr_o(nv_addr), .nv_rdata_i(nv_rdata), .nv_wdata_o(nv_wdata),
    .nv_wr_o(nv_wr), .nv_erase_o(nv_erase), .nv_erase_page_o(page),
    .erase_busy_o(busy), .download_done_o(dl_done), .ram_wr_o(ram_wr),
    .ram_addr_o(ram_addr), .ram_wdata_o(ram_wdata),
    .config_update_control_o(cfg));
  // core clock
  initial begin
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic check(input string what, input logic [27:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watcher: every output event takes the oldest note
  always @(negedge clock_i) begin
    logic [27:0] got;
    logic hit;
    hit = 1'b1;
    if (busy === 1'b1) busy_cnt++;
    if (ram_wr !== 1'b0) got = {4'h1, 8'h00, ram_addr, ram_wdata};
    else if (nv_wr !== 1'b0) got = {4'h2, nv_addr, nv_wdata};
    else if (nv_erase !== 1'b0) got = {4'h3, 13'h0000, page};
    else if (m.rd_tgl != rd_seen) got = {4'h4, 16'h0000, m.rd_val};
    else hit = 1'b0;
    rd_seen = m.rd_tgl;
    if (hit && expq.size() == 0) check("event", got, 28'h0000000);
    else if (hit) check("event", got, expq.pop_front());
  end
  // hang guard
  initial begin
    #480000;
    n_mismatch++;
    end_sim();
  end
  task automatic addr_ph(input logic [1:0] sel, input logic rw, exp);
    logic ack;
    m.start();
    m.wr_byte({smrs_pkg::ADDR_FIXED, sel, rw}, ack);
    check("addr ack", 28'(ack), 28'(exp));
  endtask
  task automatic wr_seq(input int n, input logic [7:0] c, d0, d1,
                        input logic ok);
    logic ack;
    logic [7:0] b [3];
    b = '{c, d0, d1};
    addr_ph({a_hi, a_lo}, 1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.wr_byte(b[i], ack);
      check("byte ack", 28'(ack), 28'(ok));
    end
    m.stop();
  endtask
  task automatic rd_one(input logic [7:0] exp);
    logic [7:0] v;
    expq.push_back({4'h4, 16'h0000, exp});
    addr_ph({a_hi, a_lo}, 1'b1, 1'b1);
    m.rd_byte(1'b1, v);
    m.stop();
  endtask
  // waits on a level under a bound
  task automatic wait_lvl(input int which, input logic lvl);
    for (int c = 0; (which ? busy : dl_done) !== lvl; c++) begin
      if (c > 5000) begin
        n_mismatch++;
        end_sim();
      end
      @(negedge clock_i);
    end
  endtask
  // main sequence
  initial begin
    logic [7:0] ra, rd;
    logic ack;
    void'($urandom(12102));
    repeat (12) @(posedge clock_i);
    @(negedge clock_i) nrst_i = 1'b1;
    addr_ph(2'b00, 1'b0, 1'b0);
    m.stop();
    check("dl early", 28'(dl_done), 28'h0000000);
    wait_lvl(0, 1'b1);
    // every strap setting, matching and foreign address
    for (int s = 0; s < 4; s++) begin
      @(negedge clock_i) {a_hi, a_lo} = 2'(s);
      repeat (4) @(negedge clock_i);
      addr_ph(2'(s), 1'b0, 1'b1);
      m.stop();
      addr_ph(2'(s) ^ 2'($urandom_range(1, 3)), 1'b0, 1'b0);
      m.stop();
    end
    // random ram write, pointer load, read back
    ra = 8'($urandom_range(0, 8'hDF));
    rd = 8'($urandom);
    expq.push_back({4'h1, 8'h00, ra, rd});
    wr_seq(2, ra, rd, 8'h00, 1'b1);
    wr_seq(1, ra, 8'h00, 8'h00, 1'b1);
    rd_one(rd);
    // identification registers ignore writes
    for (int i = 0; i < 4; i++) begin
      wr_seq(2, smrs_pkg::REG_MAKER_ID + 8'(i), ~IDV[i], 8'h00, 1'b1);
      rd_one(IDV[i]);
    end
    // block write then block read from ram
    wr_seq(1, 8'h30, 8'h00, 8'h00, 1'b1);
    expq.push_back({4'h1, 8'h00, 8'h30, 8'h9D});
    wr_seq(3, smrs_pkg::CMD_BLK_WR, 8'h01, 8'h9D, 1'b1);
    expq.push_back({4'h1, 8'h00, 8'h31, 8'h62});
    wr_seq(2, 8'h31, 8'h62, 8'h00, 1'b1);
    wr_seq(1, 8'h30, 8'h00, 8'h00, 1'b1);
    addr_ph({a_hi, a_lo}, 1'b0, 1'b1);
    m.wr_byte(smrs_pkg::CMD_BLK_RD, ack);
    check("blk ack", 28'(ack), 28'h1);
    addr_ph({a_hi, a_lo}, 1'b1, 1'b1);
    expq.push_back({4'h4, 16'h0000, smrs_pkg::BLK_RD_COUNT});
    expq.push_back({4'h4, 16'h0000, 8'h9D});
    expq.push_back({4'h4, 16'h0000, 8'h62});
    m.rd_byte(1'b0, rd);
    m.rd_byte(1'b0, rd);
    m.rd_byte(1'b1, rd);
    m.stop();
    // unknown command: acked, nothing stored
    wr_seq(2, 8'hE5, 8'h77, 8'h00, 1'b1);
    // erase refused while enable clear, then run and timed once set
    expq.push_back({4'h1, 8'h00, smrs_pkg::REG_CFG_UPD, 8'h00});
    wr_seq(2, smrs_pkg::REG_CFG_UPD, 8'h00, 8'h00, 1'b1);
    wr_seq(2, 8'hF8, 8'h47, 8'h00, 1'b1);
    wr_seq(1, smrs_pkg::CMD_ERASE, 8'h00, 8'h00, 1'b1);
    expq.push_back({4'h1, 8'h00, smrs_pkg::REG_CFG_UPD, 8'h04});
    wr_seq(2, smrs_pkg::REG_CFG_UPD, 8'h04, 8'h00, 1'b1);
    check("cfg", 28'(cfg), 28'h0000004);
    wr_seq(2, 8'hF8, 8'h47, 8'h00, 1'b1);
    expq.push_back({4'h3, 13'h0000, 11'h7C2});
    busy_cnt = 0;
    wr_seq(1, smrs_pkg::CMD_ERASE, 8'h00, 8'h00, 1'b1);
    addr_ph({a_hi, a_lo}, 1'b0, 1'b0);
    m.stop();
    wait_lvl(1, 1'b0);
    check("busy len", 28'(busy_cnt inside {[ERC - 1:ERC + 1]}), 28'h1);
    addr_ph({a_hi, a_lo}, 1'b0, 1'b1);
    m.stop();
    // program blank byte, then a programmed one is dropped
    rd = 8'($urandom);
    expq.push_back({4'h2, 16'hF910, rd});
    wr_seq(3, 8'hF9, 8'h10, rd, 1'b1);
    @(negedge clock_i) nv_rdata = 8'h3C;
    wr_seq(3, 8'hF9, 8'h11, rd, 1'b1);
    @(negedge clock_i) nv_rdata = 8'hFF;
    // engine running locks its range
    @(negedge clock_i) eng_run = 1'b1;
    wr_seq(2, 8'hFA, 8'h00, 8'h00, 1'b0);
    @(negedge clock_i) eng_run = 1'b0;
    repeat (50) @(negedge clock_i);
    check("pending", 28'(expq.size()), 28'h0000000);
    end_sim();
  end
endmodule
